// ==== scpmc_pkg.sv ====
// Purpose: constants and types of the clock and power mode controller
// Assumes: 32-bit Avalon-MM register window, byte addressed
// Notes: one register per aligned word
package scpmc_pkg;

  // register byte offsets
  localparam logic [3:0] ADDR_CLK = 4'h0;
  localparam logic [3:0] ADDR_PM = 4'h4;
  localparam logic [3:0] ADDR_LP = 4'h8;
  localparam logic [3:0] ADDR_STAT = 4'hc;

  // clock control fields
  localparam int CLK_PSC_LSB = 0;
  localparam int CLK_SEL_LSB = 4;
  localparam int CLK_RDY_BIT = 7;
  localparam int CLK_FAST_EN_BIT = 8;
  localparam int CLK_EXT_EN_BIT = 9;
  localparam int CLK_RING_EN_BIT = 10;
  localparam int CLK_FAST_RDY_BIT = 12;
  localparam int CLK_EXT_RDY_BIT = 13;
  localparam int CLK_RING_RDY_BIT = 14;

  // power mode fields
  localparam int PM_MODE_LSB = 0;
  localparam int PM_GPIOWK_BIT = 4;
  localparam int PM_RTCWK_BIT = 5;
  localparam int PM_HFIOPD_BIT = 8;

  // low power control fields
  localparam int LP_RAMRET_LSB = 0;
  localparam int LP_RETREG_BIT = 8;

  // status fields
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_RETAIN_LSB = 4;

  // source selection codes
  localparam logic [1:0] SEL_FAST = 2'h0;
  localparam logic [1:0] SEL_RING = 2'h1;
  localparam logic [1:0] SEL_EXT = 2'h2;

  // reset values and mode field codes
  localparam logic [2:0] PSC_RST = 3'h1;
  localparam logic [1:0] SEL_RST = SEL_FAST;
  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_BACKUP = 3'h4;
  localparam logic [3:0] RAMRET_RST = 4'h0;

  typedef enum logic [3:0] {
    ST_ACTIVE = 4'h1,
    ST_SLEEP = 4'h2,
    ST_DEEP = 4'h4,
    ST_BACKUP = 4'h8
  } scpmc_mode_type;

endpackage

// ==== scpmc_top.sv ====
// Purpose: system oscillator selection, prescaler and power mode sequencing
// Assumes: oscillators arrive as one-cycle tick enables synchronous to clk_sys
// Notes: clock outputs are tick enables, one clk_sys cycle wide
// Operation
// RQ1: system clock tick is selected source divided by two to the prescaler
// RQ2: core and bus clock at system rate, peripheral clock at half rate
// RQ3: source chosen among fast internal, ring and external slow oscillator
// RQ4: only power-on reset clears the external slow oscillator enable
// RQ5: system or watchdog reset restores fast enable, selection zero, prescaler one
// RQ6: selecting a source whose ready reads zero is refused, selection kept
// RQ7: software enables an oscillator and checks ready before selecting it
// RQ8: selection change clears clock ready, old source runs until switchover
// RQ9: software polls clock ready after a selection change
// RQ10: ring oscillator is on from power-up and cannot be disabled
// RQ11: software keeps external slow oscillator on while the real-time clock runs
// RQ12: enabled alarm wakes from sleep or deep sleep while slow oscillator runs
// RQ13: deep sleep request inhibited unless fast oscillator power-down bit set
// RQ14: four modes; processor executes only in active mode
// RQ15: wait instruction enters sleep or deep sleep by the deep select bit
// RQ16: sleep wakes on any interrupt; deeper modes on gpio, alarm or reset
// RQ17: sleep gates core clock only; oscillators keep running
// RQ18: deep sleep gates all internal clocks; state is retained
// RQ19: deep sleep ram retention per sector, off by default
// RQ20: backup stops fast oscillator, loses core state, keeps always-on state
// RQ21: backup retains a sector only with regulator and sector select set
// RQ22: writing four to the mode field enters backup at once
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ns
module scpmc_top
  import scpmc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic fast_osc_tick,
  input wire logic ring_osc_tick,
  input wire logic ext_osc_tick,
  input wire logic fast_osc_ready,
  input wire logic ring_osc_ready,
  input wire logic ext_osc_ready,
  input wire logic sys_reset_req,
  input wire logic wdt_reset_req,
  input wire logic cpu_wait_req,
  input wire logic cpu_deep_sel,
  input wire logic any_irq,
  input wire logic wdt_irq,
  input wire logic rtc_alarm,
  input wire logic gpio_irq,
  input wire logic ext_reset_wake,
  output logic core_clk_tick,
  output logic ahb_clk_tick,
  output logic apb_clk_tick,
  output logic fast_osc_en,
  output logic ring_osc_en,
  output logic ext_osc_en,
  output logic cpu_run,
  output logic core_state_lost,
  output logic [3:0] ram_retain,
  output logic [3:0] op_mode
);

  // byte lane merge of a write into a word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_w,
                                             input logic [31:0] new_w,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_w;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // mask of prescaler counter bits for 2**psc
  function automatic logic [6:0] div_mask(input logic [2:0] psc);
    logic [7:0] m;
    m = (8'h01 << psc) - 8'h01;
    return m[6:0];
  endfunction

  logic [2:0] psc_r, psc_nxt;
  logic [1:0] sel_r, sel_nxt;
  logic [1:0] act_r, act_nxt;
  logic rdy_r, rdy_nxt;
  logic fast_en_r, fast_en_nxt;
  logic ext_en_r, ext_en_nxt;
  logic [2:0] mode_fld_r, mode_fld_nxt;
  logic gpiowk_r, gpiowk_nxt;
  logic rtcwk_r, rtcwk_nxt;
  logic hfiopd_r, hfiopd_nxt;
  logic [3:0] ramret_r, ramret_nxt;
  logic retreg_r, retreg_nxt;
  scpmc_mode_type st_r, st_nxt;
  logic [6:0] div_r, div_nxt;
  logic apb_ph_r, apb_ph_nxt;
  logic core_tick_r, core_tick_nxt;
  logic ahb_tick_r, ahb_tick_nxt;
  logic apb_tick_r, apb_tick_nxt;
  logic fast_out_r, fast_out_nxt;
  logic ring_out_r;
  logic ext_out_r, ext_out_nxt;
  logic run_r, run_nxt;
  logic lost_r, lost_nxt;
  logic [3:0] retain_r, retain_nxt;
  logic [3:0] opm_r, opm_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  logic fast_rdy;
  logic ext_rdy;
  logic wr_take;
  logic rtc_wake;
  logic deep_wake;
  logic sleep_wake;
  logic [31:0] clk_word;
  logic [31:0] pm_word;
  logic [31:0] lp_word;
  logic [31:0] stat_word;
  logic [31:0] rd_word;

  assign fast_rdy = fast_osc_ready & fast_en_r;
  assign ext_rdy = ext_osc_ready & ext_en_r;
  assign wr_take = avs_write & ~wait_r;

  // RQ12: alarm needs slow osc running
  assign rtc_wake = rtc_alarm & rtcwk_r & ext_rdy;
  // RQ16: wake sources per mode
  assign deep_wake = (gpio_irq & gpiowk_r) | rtc_wake | ext_reset_wake;
  assign sleep_wake = any_irq | wdt_irq | gpio_irq | rtc_wake | ext_reset_wake;

  always_comb begin
    clk_word = 32'h0;
    clk_word[CLK_PSC_LSB +: 3] = psc_r;
    clk_word[CLK_SEL_LSB +: 2] = sel_r;
    clk_word[CLK_RDY_BIT] = rdy_r;
    clk_word[CLK_FAST_EN_BIT] = fast_en_r;
    clk_word[CLK_EXT_EN_BIT] = ext_en_r;
    clk_word[CLK_RING_EN_BIT] = 1'b1;
    clk_word[CLK_FAST_RDY_BIT] = fast_rdy;
    clk_word[CLK_EXT_RDY_BIT] = ext_rdy;
    clk_word[CLK_RING_RDY_BIT] = ring_osc_ready;
    pm_word = 32'h0;
    pm_word[PM_MODE_LSB +: 3] = mode_fld_r;
    pm_word[PM_GPIOWK_BIT] = gpiowk_r;
    pm_word[PM_RTCWK_BIT] = rtcwk_r;
    pm_word[PM_HFIOPD_BIT] = hfiopd_r;
    lp_word = 32'h0;
    lp_word[LP_RAMRET_LSB +: 4] = ramret_r;
    lp_word[LP_RETREG_BIT] = retreg_r;
    stat_word = 32'h0;
    stat_word[STAT_MODE_LSB +: 4] = st_r;
    stat_word[STAT_RETAIN_LSB +: 4] = retain_r;
    unique case (avs_address)
      ADDR_CLK: rd_word = clk_word;
      ADDR_PM: rd_word = pm_word;
      ADDR_LP: rd_word = lp_word;
      ADDR_STAT: rd_word = stat_word;
      default: rd_word = 32'h0;
    endcase
  end

  // bus slave: one wait cycle, then answer
  always_comb begin
    wait_nxt = 1'b1;
    rdata_nxt = rdata_r;
    if ((avs_read | avs_write) & wait_r) begin
      wait_nxt = 1'b0;
      rdata_nxt = avs_read ? rd_word : 32'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end else begin
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign avs_waitrequest = wait_r;
  assign avs_readdata = rdata_r;

  always_comb begin
    logic [31:0] wv;
    logic [1:0] new_sel;
    logic src_tick;
    logic new_tick;
    logic sys_tick;
    logic osc_ok;
    wv = 32'h0;
    new_sel = sel_r;
    src_tick = 1'b0;
    new_tick = 1'b0;
    sys_tick = 1'b0;
    osc_ok = 1'b0;
    psc_nxt = psc_r;
    sel_nxt = sel_r;
    act_nxt = act_r;
    rdy_nxt = rdy_r;
    fast_en_nxt = fast_en_r;
    ext_en_nxt = ext_en_r;
    mode_fld_nxt = mode_fld_r;
    gpiowk_nxt = gpiowk_r;
    rtcwk_nxt = rtcwk_r;
    hfiopd_nxt = hfiopd_r;
    ramret_nxt = ramret_r;
    retreg_nxt = retreg_r;
    st_nxt = st_r;
    div_nxt = div_r;
    apb_ph_nxt = apb_ph_r;
    lost_nxt = 1'b0;

    // RQ3: three selectable sources
    unique case (act_r)
      SEL_RING: src_tick = ring_osc_tick;
      SEL_EXT: src_tick = ext_osc_tick;
      default: src_tick = fast_osc_tick;
    endcase
    unique case (sel_r)
      SEL_RING: new_tick = ring_osc_tick;
      SEL_EXT: new_tick = ext_osc_tick;
      default: new_tick = fast_osc_tick;
    endcase

    // RQ8: switch on first tick of new source
    if (!rdy_r && new_tick) begin
      act_nxt = sel_r;
      rdy_nxt = 1'b1;
      div_nxt = 7'h0;
    end else if (src_tick) begin
      // RQ1: divide by two to the psc
      if ((div_r & div_mask(psc_r)) == div_mask(psc_r)) begin
        div_nxt = 7'h0;
        sys_tick = 1'b1;
      end else begin
        div_nxt = 7'(div_r + 7'h1);
      end
    end

    // RQ2: peripheral clock at half rate
    if (sys_tick) begin
      apb_ph_nxt = ~apb_ph_r;
    end

    // RQ14: mode sequencing
    unique case (st_r)
      ST_ACTIVE: begin
        // RQ15: wait instruction entry
        if (cpu_wait_req) begin
          if (!cpu_deep_sel) begin
            st_nxt = ST_SLEEP;
          // RQ13: deep sleep needs power-down bit
          end else if (hfiopd_r) begin
            st_nxt = ST_DEEP;
          end
        end
      end
      ST_SLEEP: begin
        if (sleep_wake) begin
          st_nxt = ST_ACTIVE;
        end
      end
      ST_DEEP: begin
        if (deep_wake) begin
          st_nxt = ST_ACTIVE;
        end
      end
      ST_BACKUP: begin
        if (deep_wake) begin
          st_nxt = ST_ACTIVE;
          lost_nxt = 1'b1;
        end
      end
      default: st_nxt = ST_ACTIVE;
    endcase

    if (wr_take) begin
      unique case (avs_address)
        ADDR_CLK: begin
          wv = lane_merge(clk_word, avs_writedata, avs_byteenable);
          psc_nxt = wv[CLK_PSC_LSB +: 3];
          fast_en_nxt = wv[CLK_FAST_EN_BIT];
          ext_en_nxt = wv[CLK_EXT_EN_BIT];
          new_sel = wv[CLK_SEL_LSB +: 2];
          unique case (new_sel)
            SEL_FAST: osc_ok = fast_rdy;
            SEL_RING: osc_ok = ring_osc_ready;
            SEL_EXT: osc_ok = ext_rdy;
            default: osc_ok = 1'b0;
          endcase
          // RQ6: refuse source not ready
          if (new_sel != sel_r && osc_ok) begin
            sel_nxt = new_sel;
            // RQ8: clear ready on change
            rdy_nxt = 1'b0;
          end
        end
        ADDR_PM: begin
          wv = lane_merge(pm_word, avs_writedata, avs_byteenable);
          mode_fld_nxt = wv[PM_MODE_LSB +: 3];
          gpiowk_nxt = wv[PM_GPIOWK_BIT];
          rtcwk_nxt = wv[PM_RTCWK_BIT];
          hfiopd_nxt = wv[PM_HFIOPD_BIT];
          // RQ22: backup entered at once
          if (wv[PM_MODE_LSB +: 3] == MODE_BACKUP) begin
            st_nxt = ST_BACKUP;
          end
        end
        ADDR_LP: begin
          wv = lane_merge(lp_word, avs_writedata, avs_byteenable);
          ramret_nxt = wv[LP_RAMRET_LSB +: 4];
          retreg_nxt = wv[LP_RETREG_BIT];
        end
        default: begin
        end
      endcase
    end

    // RQ5: system, watchdog or backup exit defaults
    // RQ4: slow osc enable kept here
    // RQ20: always-on fields kept on backup exit
    if (sys_reset_req | wdt_reset_req | lost_nxt) begin
      psc_nxt = PSC_RST;
      sel_nxt = SEL_RST;
      act_nxt = SEL_RST;
      rdy_nxt = 1'b1;
      fast_en_nxt = 1'b1;
      mode_fld_nxt = MODE_ACTIVE;
      gpiowk_nxt = 1'b0;
      rtcwk_nxt = 1'b0;
      hfiopd_nxt = 1'b0;
      div_nxt = 7'h0;
      apb_ph_nxt = 1'b0;
      st_nxt = ST_ACTIVE;
      sys_tick = 1'b0;
    end

    // RQ17: sleep gates only the core
    core_tick_nxt = sys_tick & (st_nxt == ST_ACTIVE);
    // RQ18: deep sleep gates all clocks
    ahb_tick_nxt = sys_tick & (st_nxt inside {ST_ACTIVE, ST_SLEEP});
    apb_tick_nxt = sys_tick & apb_ph_r & (st_nxt inside {ST_ACTIVE, ST_SLEEP});
    // RQ20: fast osc off in backup
    fast_out_nxt = fast_en_nxt & (st_nxt != ST_BACKUP) & ~((st_nxt == ST_DEEP) & hfiopd_nxt);
    ext_out_nxt = ext_en_nxt;
    run_nxt = (st_nxt == ST_ACTIVE);
    opm_nxt = st_nxt;
    // RQ21: backup retention needs regulator
    // RQ19: per-sector retention select
    retain_nxt = (st_nxt == ST_BACKUP) ? (retreg_nxt ? ramret_nxt : 4'h0) : ramret_nxt;
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      psc_r <= PSC_RST;
      sel_r <= SEL_RST;
      act_r <= SEL_RST;
      rdy_r <= 1'b1;
      fast_en_r <= 1'b1;
      // RQ4: power-on clears slow osc enable
      ext_en_r <= 1'b0;
      mode_fld_r <= MODE_ACTIVE;
      gpiowk_r <= 1'b0;
      rtcwk_r <= 1'b0;
      hfiopd_r <= 1'b0;
      ramret_r <= RAMRET_RST;
      retreg_r <= 1'b0;
      st_r <= ST_ACTIVE;
      div_r <= 7'h0;
      apb_ph_r <= 1'b0;
      core_tick_r <= 1'b0;
      ahb_tick_r <= 1'b0;
      apb_tick_r <= 1'b0;
      fast_out_r <= 1'b1;
      // RQ10: ring always on
      ring_out_r <= 1'b1;
      ext_out_r <= 1'b0;
      run_r <= 1'b1;
      lost_r <= 1'b0;
      retain_r <= RAMRET_RST;
      opm_r <= ST_ACTIVE;
    end else begin
      psc_r <= psc_nxt;
      sel_r <= sel_nxt;
      act_r <= act_nxt;
      rdy_r <= rdy_nxt;
      fast_en_r <= fast_en_nxt;
      ext_en_r <= ext_en_nxt;
      mode_fld_r <= mode_fld_nxt;
      gpiowk_r <= gpiowk_nxt;
      rtcwk_r <= rtcwk_nxt;
      hfiopd_r <= hfiopd_nxt;
      ramret_r <= ramret_nxt;
      retreg_r <= retreg_nxt;
      st_r <= st_nxt;
      div_r <= div_nxt;
      apb_ph_r <= apb_ph_nxt;
      core_tick_r <= core_tick_nxt;
      ahb_tick_r <= ahb_tick_nxt;
      apb_tick_r <= apb_tick_nxt;
      fast_out_r <= fast_out_nxt;
      ring_out_r <= 1'b1;
      ext_out_r <= ext_out_nxt;
      run_r <= run_nxt;
      lost_r <= lost_nxt;
      retain_r <= retain_nxt;
      opm_r <= opm_nxt;
    end
  end

  assign core_clk_tick = core_tick_r;
  assign ahb_clk_tick = ahb_tick_r;
  assign apb_clk_tick = apb_tick_r;
  assign fast_osc_en = fast_out_r;
  assign ring_osc_en = ring_out_r;
  assign ext_osc_en = ext_out_r;
  assign cpu_run = run_r;
  assign core_state_lost = lost_r;
  assign ram_retain = retain_r;
  assign op_mode = opm_r;

endmodule

// ==== scpmc_assertions.sv ====
// Purpose: port checks of the clock and power mode controller
// Assumes: one clock domain, reset_n active low
// Notes: bound to scpmc_top below
`timescale 1ns/1ns
module scpmc_assertions (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic core_clk_tick,
  input wire logic ahb_clk_tick,
  input wire logic apb_clk_tick,
  input wire logic fast_osc_en,
  input wire logic ring_osc_en,
  input wire logic cpu_run,
  input wire logic core_state_lost,
  input wire logic [3:0] op_mode
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_ring_on; ring_osc_en; endproperty
  a_ring_on: assert property (p_ring_on) else $error("ring oscillator off");
  property p_onehot; $onehot(op_mode); endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");
  property p_run_active; cpu_run == (op_mode == 4'h1); endproperty
  a_run_active: assert property (p_run_active) else $error("cpu run outside active");
  property p_core_in_ahb; core_clk_tick |-> ahb_clk_tick; endproperty
  a_core_in_ahb: assert property (p_core_in_ahb) else $error("core tick without bus tick");
  property p_apb_in_ahb; apb_clk_tick |-> ahb_clk_tick ##1 !apb_clk_tick; endproperty
  a_apb_in_ahb: assert property (p_apb_in_ahb) else $error("peripheral tick off rate");
  property p_sleep_gate; op_mode == 4'h2 |-> !core_clk_tick && !cpu_run; endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("core clock in sleep");
  property p_deep_gate; op_mode == 4'h4 |-> !ahb_clk_tick && !apb_clk_tick && !fast_osc_en; endproperty
  a_deep_gate: assert property (p_deep_gate) else $error("clock running in deep sleep");
  property p_backup_off; op_mode == 4'h8 |-> !fast_osc_en && !ahb_clk_tick; endproperty
  a_backup_off: assert property (p_backup_off) else $error("fast oscillator on in backup");
  property p_lost_pulse; core_state_lost |=> !core_state_lost; endproperty
  a_lost_pulse: assert property (p_lost_pulse) else $error("state lost not a pulse");
endmodule
bind scpmc_top scpmc_assertions u_chk (.clk_sys, .reset_n, .core_clk_tick, .ahb_clk_tick,
  .apb_clk_tick, .fast_osc_en, .ring_osc_en, .cpu_run, .core_state_lost, .op_mode);

// ==== testbench.sv ====
// Purpose: register and mode tests of scpmc_top
// Assumes: oscillator ticks made here on a cycle grid
// Notes: tick counts allow one of phase slack
`timescale 1ns/1ns
module testbench;
  import scpmc_pkg::*;
  logic clk_sys = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdv;
  logic avs_waitrequest, fast_osc_tick = 1'b0, ring_osc_tick = 1'b0, ext_osc_tick = 1'b0;
  logic fast_osc_ready = 1'b1, ring_osc_ready = 1'b1, ext_osc_ready = 1'b0, ring_run = 1'b1;
  logic sys_reset_req = 1'b0, wdt_reset_req = 1'b0, cpu_wait_req = 1'b0, cpu_deep_sel = 1'b0;
  logic rtc_alarm = 1'b0, ext_reset_wake = 1'b0;
  logic [2:0] wk = 3'h0;
  logic core_clk_tick, ahb_clk_tick, apb_clk_tick, fast_osc_en, ring_osc_en, ext_osc_en;
  logic cpu_run, core_state_lost;
  logic [3:0] ram_retain, op_mode;
  int errors = 0, checked = 0, cyc = 0, n_ahb = 0, n_apb = 0, n_core = 0, n_lost = 0;

  scpmc_top dut (.clk_sys, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .fast_osc_tick, .ring_osc_tick,
    .ext_osc_tick, .fast_osc_ready, .ring_osc_ready, .ext_osc_ready, .sys_reset_req, .wdt_reset_req,
    .cpu_wait_req, .cpu_deep_sel, .any_irq(wk[0]), .wdt_irq(wk[1]), .rtc_alarm, .gpio_irq(wk[2]),
    .ext_reset_wake, .core_clk_tick, .ahb_clk_tick, .apb_clk_tick, .fast_osc_en, .ring_osc_en,
    .ext_osc_en, .cpu_run, .core_state_lost, .ram_retain, .op_mode);

  always #20 clk_sys = ~clk_sys;

  always @(posedge clk_sys) begin
    cyc++;
    fast_osc_tick <= (cyc % 2 == 0);
    ring_osc_tick <= ring_run && (cyc % 8 == 0);
    ext_osc_tick <= (cyc % 5 == 0);
    if (cyc > 30000) begin
      errors++;
      report_and_stop;
    end
  end

  always @(negedge clk_sys) begin
    n_ahb += int'(ahb_clk_tick === 1'b1);
    n_apb += int'(apb_clk_tick === 1'b1);
    n_core += int'(core_clk_tick === 1'b1);
    n_lost += int'(core_state_lost === 1'b1);
  end

  task report_and_stop;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task near(input string nm, input int e, input int g);
    checked++;
    if (g < e - 1 || g > e + 1) begin
      errors++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [3:0] a);
    avs_address <= a;
    avs_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdv = avs_readdata;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask

  task poll;
    int c;
    c = 0;
    do begin
      rd(ADDR_CLK);
      c++;
    end while (rdv[CLK_RDY_BIT] !== 1'b1 && c < 40);
    chk("clock ready", 32'h1, 32'(rdv[CLK_RDY_BIT]));
  endtask

  task rate(input int e);
    n_ahb = 0;
    n_apb = 0;
    n_core = 0;
    repeat (512) @(posedge clk_sys);
    near("ahb ticks", e, n_ahb);
    near("apb ticks", e / 2, n_apb);
    near("core ticks", e, n_core);
  endtask

  task settle(input string nm, input logic [3:0] e);
    repeat (3) @(posedge clk_sys);
    chk(nm, 32'(e), 32'(op_mode));
  endtask

  task wt(input logic [3:0] e);
    cpu_wait_req <= 1'b1;
    @(posedge clk_sys);
    cpu_wait_req <= 1'b0;
    settle("mode after wait", e);
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(ADDR_CLK);
    chk("clock ctrl", 32'h5581, rdv);
    chk("ext enable", 32'h0, 32'(ext_osc_en));
    rd(ADDR_STAT);
    chk("status", 32'h1, rdv);
    rd(4'h2);
    chk("unmapped", 32'h0, rdv);
    for (int p = 0; p < 8; p++) begin
      wr(ADDR_CLK, 32'h100 | p);
      rate(256 >> p);
    end
    for (int s = 2; s < 4; s++) begin
      wr(ADDR_CLK, 32'h100 | (s << 4));
      rd(ADDR_CLK);
      chk("refused select", 32'h0, 32'(rdv[5:4]));
    end
    ext_osc_ready <= 1'b1;
    wr(ADDR_CLK, 32'h300);
    rd(ADDR_CLK);
    chk("ext ready", 32'h1, 32'(rdv[CLK_EXT_RDY_BIT]));
    ring_run <= 1'b0;
    wr(ADDR_CLK, 32'h310);
    rd(ADDR_CLK);
    chk("pending switch", 32'h1, 32'({rdv[CLK_RDY_BIT], rdv[5:4]}));
    rate(256);
    ring_run <= 1'b1;
    poll;
    rate(64);
    wr(ADDR_CLK, 32'h320);
    poll;
    rate(102);
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_CLK, 32'h320);
      poll;
      sys_reset_req <= (k == 0);
      wdt_reset_req <= (k == 1);
      @(posedge clk_sys);
      sys_reset_req <= 1'b0;
      wdt_reset_req <= 1'b0;
      @(posedge clk_sys);
      rd(ADDR_CLK);
      chk("after reset", 32'h7781, rdv);
    end
    for (int i = 0; i < 3; i++) begin
      wt(4'h2);
      chk("cpu run", 32'h0, 32'(cpu_run));
      wk <= 3'h1 << i;
      settle("sleep wake", 4'h1);
      wk <= 3'h0;
      @(posedge clk_sys);
    end
    cpu_deep_sel <= 1'b1;
    wt(4'h1);
    wr(ADDR_PM, 32'h120);
    wt(4'h4);
    chk("fast enable", 32'h0, 32'(fast_osc_en));
    wk <= 3'h3;
    settle("deep no wake", 4'h4);
    wk <= 3'h0;
    chk("ext enable", 32'h1, 32'(ext_osc_en));
    rtc_alarm <= 1'b1;
    settle("alarm wake", 4'h1);
    rtc_alarm <= 1'b0;
    cpu_deep_sel <= 1'b0;
    wr(ADDR_LP, 32'h10a);
    wr(ADDR_PM, 32'h4);
    settle("backup", 4'h8);
    chk("retain", 32'ha, 32'(ram_retain));
    chk("fast enable", 32'h0, 32'(fast_osc_en));
    ext_reset_wake <= 1'b1;
    settle("reset wake", 4'h1);
    ext_reset_wake <= 1'b0;
    chk("retain active", 32'ha, 32'(ram_retain));
    wr(ADDR_LP, 32'h00a);
    wr(ADDR_PM, 32'h14);
    settle("backup", 4'h8);
    chk("retain", 32'h0, 32'(ram_retain));
    wk <= 3'h4;
    settle("gpio wake", 4'h1);
    wk <= 3'h0;
    avs_byteenable <= 4'h1;
    wr(ADDR_LP, 32'h105);
    avs_byteenable <= 4'hf;
    rd(ADDR_LP);
    chk("lane merge", 32'h5, rdv);
    chk("state lost pulses", 32'h2, 32'(n_lost));
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("ext enable", 32'h0, 32'(ext_osc_en));
    report_and_stop;
  end
endmodule
